// ---- dpcd_pkg.sv ----
package dpcd_pkg;

   // ----------------------------------------------------------------
   // widths and link address
   // ----------------------------------------------------------------
   localparam int REG_W = 9;
   localparam int DATA_W = 10;
   localparam int WIPER_BITS_DEF = 8;
   localparam logic [6:0] DEV_ADDR = 7'h2E;

   // ----------------------------------------------------------------
   // device memory map (command byte address field)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_WIPER_ZERO = 4'h0;
   localparam logic [3:0] ADDR_WIPER_ONE = 4'h1;
   localparam logic [3:0] ADDR_TERMINAL_CONNECTION_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_PTR_RESET = 4'h0;

   // reset values
   localparam logic [8:0] WIPER_RESET = 9'h080;
   localparam logic [8:0] TERMINAL_CONNECTION_CONTROL_RESET = 9'h1FF;
   localparam logic [8:0] STATUS_VALUE = 9'h000;

   // ----------------------------------------------------------------
   // command byte layout and operation codes
   // ----------------------------------------------------------------
   localparam int CB_ADDR_LSB = 4;
   localparam int CB_OP_LSB = 2;
   localparam int CB_SPARE_BIT = 1;
   localparam int CB_UPPER_BIT = 0;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_INC = 2'h1;
   localparam logic [1:0] OP_DEC = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;

   // ----------------------------------------------------------------
   // controller registers on the peripheral bus
   // ----------------------------------------------------------------
   localparam logic [31:0] OFS_CMD = 32'h0000_0000;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
   localparam int CMDF_ADDR_LSB = 0;
   localparam int CMDF_OP_LSB = 4;
   localparam int CMDF_HV_BIT = 6;
   localparam int CMDF_DATA_LSB = 8;
   localparam int STF_BUSY = 0;
   localparam int STF_NACK = 1;
   localparam int STF_DONE = 2;
   localparam int STF_RDATA_LSB = 16;

   // ----------------------------------------------------------------
   // link timing
   // ----------------------------------------------------------------
   localparam int PCLK_PERIOD_NS = 40;
   localparam int SCL_QUARTER_NS = 625;
   localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

   typedef enum logic [2:0] {STEP_START, STEP_TX, STEP_RXA, STEP_RXN, STEP_STOP, STEP_END}
      dpcd_step_t;

endpackage : dpcd_pkg

// ---- dpcd_link_if.sv ----
`timescale 1ns/10ps
interface dpcd_link_if;
   logic scl_out;
   logic scl_oe;
   logic sda_host_out;
   logic sda_host_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic hvc_elevated;
   logic scl;
   logic sda;

   // sda open-drain with pull-up; scl driven by the host when enabled, else pulled up
   assign scl = scl_oe ? scl_out : 1'b1;
   assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

   modport device (
      input scl,
      input sda,
      input hvc_elevated,
      output sda_dev_out,
      output sda_dev_oe
   );

   modport host (
      input sda,
      output scl_out,
      output scl_oe,
      output sda_host_out,
      output sda_host_oe,
      output hvc_elevated
   );
endinterface : dpcd_link_if

// ---- dpcd_device.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// R1 - wipers take write, read, increment, decrement
// R2 - terminal control takes only write and read
// R3 - every operation has single and continuous forms
// R4 - elevated pin level marks high-voltage command state
// R5 - command byte: address, operation, two data bits
// R6 - operation field picks read, write, step
// R7 - codes: write 00, inc 01, dec 10, read 11
// R8 - valid address and operation gets acknowledged
// R9 - invalid pair is not acknowledged
// R10 - after error ignore everything until start
// R11 - master sends start after rejected command
// R12 - command data bits are wiper upper bits
// R13 - stepping only on the wiper registers
// R14 - step on addresses four upward is invalid
// R15 - store nine bits, drop the spare bit
// R16 - every read returns two bytes
// R17 - only read and write carry data bytes
// R18 - write joins upper bit with data byte
// R19 - nine bits allow full scale 100h
// R20 - start or stop mid-byte aborts command
// R21 - wipers live at addresses 00h, 01h
// R22 - continuous writes to 00h, 01h, 04h
// R23 - increment saturates at full scale
// R24 - address pointer resets to 00h
module dpcd_device #(
   parameter int unsigned WIPER_BITS = dpcd_pkg::WIPER_BITS_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   dpcd_link_if.device link,
   output logic [dpcd_pkg::REG_W-1:0] wiper_zero_setting,
   output logic [dpcd_pkg::REG_W-1:0] wiper_one_setting,
   output logic [dpcd_pkg::REG_W-1:0] terminal_connection_control,
   output logic high_voltage_state,
   output logic command_error
);
   import dpcd_pkg::*;

   typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK, D_IGNORE} dpcd_dstate_t;
   typedef enum logic [1:0] {B_CTL, B_CMD, B_DATA} dpcd_kind_t;

   localparam logic [REG_W-1:0] FULL_SCALE = REG_W'(1 << WIPER_BITS);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // legal address and operation pairs
   function automatic logic cmd_valid(input logic [3:0] adr, input logic [1:0] op);
      logic ok;
      ok = 1'b0;
      case (adr)
         ADDR_WIPER_ZERO, ADDR_WIPER_ONE: ok = 1'b1;                        // [R1] [R21]
         ADDR_TERMINAL_CONNECTION_CONTROL: ok = (op == OP_WRITE) || (op == OP_READ);                // [R2] [R14]
         ADDR_STATUS: ok = (op == OP_READ);                                  // [R14]
         default: ok = 1'b0;                                                 // [R13] [R14]
      endcase
      return ok;
   endfunction : cmd_valid

   // one step up or down, held at the ends
   function automatic logic [REG_W-1:0] step_value(input logic [REG_W-1:0] v, input logic up);
      logic [REG_W-1:0] r;
      r = v;
      if (up && (v < FULL_SCALE))
         r = v + 9'h001;                                                     // [R23]
      else if (!up && (v != 9'h000) && (v <= FULL_SCALE))
         r = v - 9'h001;
      return r;
   endfunction : step_value

   // ----------------------------------------------------------------
   // pin synchronisers and bus events
   // ----------------------------------------------------------------
   logic scl_meta, scl_sync, scl_prev;
   logic sda_meta, sda_sync, sda_prev;
   logic hvc_meta, hvc_sync;

   // two flops on each pin, a third on scl and sda for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_prev <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_prev <= 1'b1;
         hvc_meta <= 1'b0;
         hvc_sync <= 1'b0;
      end
      else
      begin
         scl_meta <= link.scl;
         scl_sync <= scl_meta;
         scl_prev <= scl_sync;
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
         sda_prev <= sda_sync;
         hvc_meta <= link.hvc_elevated;
         hvc_sync <= hvc_meta;
      end
   end

   logic scl_rise, scl_fall, start_seen, stop_seen;
   assign scl_rise = scl_sync && !scl_prev;
   assign scl_fall = !scl_sync && scl_prev;
   assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;

   // ----------------------------------------------------------------
   // byte engine
   // ----------------------------------------------------------------
   dpcd_dstate_t state;
   dpcd_kind_t kind;
   logic [7:0] shift;
   logic [7:0] tx_shift;
   logic [3:0] bit_cnt;
   logic reading;
   logic tx_lo;
   logic mack_ok;
   logic [3:0] mem_ptr;
   logic [1:0] cur_op;
   logic upper_data_bit;
   logic [REG_W-1:0] read_value;

   logic [3:0] memory_address_field;
   logic [1:0] operation_code_field;
   logic byte_done, byte_ok, ack_end, apply_write, apply_step;

   // command byte split into its fields
   assign memory_address_field = shift[CB_ADDR_LSB+:4];                      // [R5]
   assign operation_code_field = shift[CB_OP_LSB+:2];                        // [R5] [R7]
   assign byte_done = (state == D_RECV) && scl_fall && (bit_cnt == 4'h8);
   assign ack_end = (state == D_ACK) && scl_fall;
   assign apply_write = ack_end && (kind == B_DATA);
   assign apply_step = ack_end && (kind == B_CMD) && ((cur_op == OP_INC) || (cur_op == OP_DEC));

   // decide whether the finished byte is acknowledged
   always_comb
   begin
      case (kind)
         B_CTL: byte_ok = (shift[7:1] == DEV_ADDR);
         B_CMD: byte_ok = cmd_valid(memory_address_field, operation_code_field); // [R8] [R9]
         default: byte_ok = 1'b1;
      endcase
   end

   // value shown to a read of the pointed location
   always_comb
   begin
      case (mem_ptr)
         ADDR_WIPER_ZERO: read_value = wiper_zero_setting;
         ADDR_WIPER_ONE: read_value = wiper_one_setting;
         ADDR_TERMINAL_CONNECTION_CONTROL: read_value = terminal_connection_control;
         ADDR_STATUS: read_value = STATUS_VALUE;
         default: read_value = 9'h000;
      endcase
   end

   // bit and byte sequencing, sda drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= D_IDLE;
         kind <= B_CTL;
         shift <= 8'h00;
         tx_shift <= 8'h00;
         bit_cnt <= 4'h0;
         reading <= 1'b0;
         tx_lo <= 1'b0;
         mack_ok <= 1'b0;
         link.sda_dev_oe <= 1'b0;
         link.sda_dev_out <= 1'b0;
      end
      else if (start_seen)
      begin
         state <= D_RECV;                                                    // [R10] [R20]
         kind <= B_CTL;
         bit_cnt <= 4'h0;
         link.sda_dev_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
         state <= D_IDLE;                                                    // [R20]
         link.sda_dev_oe <= 1'b0;
      end
      else
      begin
         case (state)
            D_RECV:
               if (scl_rise)
               begin
                  shift <= {shift[6:0], sda_sync};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               else if (byte_done)
               begin
                  if (kind == B_CTL)
                     reading <= shift[0];
                  state <= byte_ok ? D_ACK : D_IGNORE;                       // [R9] [R10]
                  link.sda_dev_oe <= byte_ok;                                // [R8]
               end
            D_ACK:
               if (scl_fall)
               begin
                  bit_cnt <= 4'h0;
                  state <= D_RECV;
                  link.sda_dev_oe <= 1'b0;
                  if (kind == B_CTL && reading)
                  begin
                     state <= D_SEND;                                        // [R16]
                     tx_lo <= 1'b0;
                     tx_shift <= {7'h00, read_value[8]};
                     link.sda_dev_oe <= 1'b1;                                // high byte opens with zero
                  end
                  else if (kind == B_CMD && cur_op == OP_WRITE)
                     kind <= B_DATA;                                         // [R17]
                  else
                     kind <= B_CMD;                                          // [R3] [R22]
               end
            D_SEND:
               if (scl_fall)
               begin
                  if (bit_cnt == 4'h7)
                  begin
                     state <= D_MACK;
                     link.sda_dev_oe <= 1'b0;
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + 4'h1;
                     tx_shift <= {tx_shift[6:0], 1'b0};
                     link.sda_dev_oe <= !tx_shift[6];
                  end
               end
            D_MACK:
               if (scl_rise)
                  mack_ok <= !sda_sync;
               else if (scl_fall)
               begin
                  bit_cnt <= 4'h0;
                  if (mack_ok)
                  begin
                     state <= D_SEND;                                        // [R3] [R16]
                     tx_lo <= !tx_lo;
                     tx_shift <= tx_lo ? {7'h00, read_value[8]} : read_value[7:0];
                     link.sda_dev_oe <= tx_lo ? 1'b1 : !read_value[7];
                  end
                  else
                     state <= D_IGNORE;
               end
            D_IDLE, D_IGNORE: state <= state;
            default: state <= D_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // command latch and error flag
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_ptr <= ADDR_PTR_RESET;                                          // [R24]
         cur_op <= OP_WRITE;
         upper_data_bit <= 1'b0;
         high_voltage_state <= 1'b0;
         command_error <= 1'b0;
      end
      else if (byte_done && kind == B_CMD)
      begin
         if (byte_ok)
         begin
            mem_ptr <= memory_address_field;
            cur_op <= operation_code_field;                                  // [R6]
            upper_data_bit <= shift[CB_UPPER_BIT];                           // [R12] [R15]
            high_voltage_state <= hvc_sync;                                  // [R4]
         end
         else
            command_error <= 1'b1;                                           // [R10]
      end
      else if (start_seen)
         command_error <= 1'b0;
   end

   // ----------------------------------------------------------------
   // register file, updated at the end of the acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wiper_zero_setting <= WIPER_RESET;
         wiper_one_setting <= WIPER_RESET;
         terminal_connection_control <= TERMINAL_CONNECTION_CONTROL_RESET;
      end
      else if (apply_write)
      begin
         case (mem_ptr)
            ADDR_WIPER_ZERO: wiper_zero_setting <= {upper_data_bit, shift};  // [R18] [R19]
            ADDR_WIPER_ONE: wiper_one_setting <= {upper_data_bit, shift};    // [R18] [R19]
            ADDR_TERMINAL_CONNECTION_CONTROL: terminal_connection_control <= {upper_data_bit, shift}; // [R2]
            default: terminal_connection_control <= terminal_connection_control;
         endcase
      end
      else if (apply_step)
      begin
         if (mem_ptr == ADDR_WIPER_ZERO)
            wiper_zero_setting <= step_value(wiper_zero_setting, cur_op == OP_INC); // [R1]
         else
            wiper_one_setting <= step_value(wiper_one_setting, cur_op == OP_INC);   // [R13]
      end
   end

endmodule : dpcd_device

// ---- dpcd_host.sv ----
`timescale 1ns/10ps
module dpcd_host (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   dpcd_link_if.host link
);
   import dpcd_pkg::*;

   // ----------------------------------------------------------------
   // transfer plan
   // ----------------------------------------------------------------
   // kind of each step of a transfer for a given operation
   function automatic dpcd_step_t step_kind(input logic [1:0] op, input logic [3:0] idx);
      dpcd_step_t k;
      k = STEP_END;
      case (idx)
         4'h0: k = STEP_START;
         4'h1, 4'h2: k = STEP_TX;
         4'h3: k = (op == OP_WRITE) ? STEP_TX : ((op == OP_READ) ? STEP_START : STEP_STOP); // [R17]
         4'h4: k = (op == OP_WRITE) ? STEP_STOP : ((op == OP_READ) ? STEP_TX : STEP_END);
         4'h5: k = (op == OP_READ) ? STEP_RXA : STEP_END;
         4'h6: k = (op == OP_READ) ? STEP_RXN : STEP_END;
         4'h7: k = (op == OP_READ) ? STEP_STOP : STEP_END;
         default: k = STEP_END;
      endcase
      return k;
   endfunction : step_kind

   // index of the stop step, taken after a refused byte
   function automatic logic [3:0] stop_index(input logic [1:0] op);
      return (op == OP_WRITE) ? 4'h4 : ((op == OP_READ) ? 4'h7 : 4'h3);
   endfunction : stop_index

   // ----------------------------------------------------------------
   // registers and sequencer state
   // ----------------------------------------------------------------
   logic [31:0] cmd;
   logic busy, nack, done;
   logic [15:0] rx;
   logic [3:0] step;
   logic [1:0] quarter;
   logic [3:0] bit_idx;
   logic [7:0] qcnt;
   logic sda_meta, sda_sync;
   logic tick;
   dpcd_step_t kind;
   logic [1:0] op;
   logic [7:0] tx_byte;
   logic wr_take, mapped;

   assign op = cmd[CMDF_OP_LSB+:2];                                          // [R7]
   assign kind = step_kind(op, step);
   assign tick = busy && (qcnt == 8'(SCL_QUARTER_CYC - 1));
   assign mapped = (paddr == OFS_CMD) || (paddr == OFS_STATUS);
   assign wr_take = psel && penable && pready && pwrite && (paddr == OFS_CMD) && !busy;

   // byte sent in the current step
   always_comb
   begin
      case (step)
         4'h2: tx_byte = {cmd[CMDF_ADDR_LSB+:4], op, cmd[CMDF_DATA_LSB+9], cmd[CMDF_DATA_LSB+8]};
         4'h3: tx_byte = cmd[CMDF_DATA_LSB+:8];
         4'h4: tx_byte = {DEV_ADDR, 1'b1};
         default: tx_byte = {DEV_ADDR, 1'b0};
      endcase
   end

   // ----------------------------------------------------------------
   // peripheral bus slave, one wait state
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         pslverr <= !mapped;
         if (paddr == OFS_CMD)
            prdata <= cmd;
         else if (paddr == OFS_STATUS)
            prdata <= {6'h00, rx[9:0], 13'h0000, done, nack, busy};
         else
            prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // command register, written only while idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cmd <= 32'h0000_0000;
      else if (wr_take)
         cmd <= pwdata & 32'h0003_FF7F;
   end

   // ----------------------------------------------------------------
   // link sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end
      else
      begin
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
      end
   end

   // position within the transfer: step, bit, quarter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         step <= 4'h0;
         bit_idx <= 4'h0;
         quarter <= 2'h0;
         qcnt <= 8'h00;
         rx <= 16'h0000;
      end
      else if (wr_take)
      begin
         busy <= 1'b1;                                                       // [R11]
         done <= 1'b0;
         nack <= 1'b0;
         step <= 4'h0;
         bit_idx <= 4'h0;
         quarter <= 2'h0;
         qcnt <= 8'h00;
      end
      else if (busy && kind == STEP_END)
      begin
         busy <= 1'b0;
         done <= 1'b1;
      end
      else if (busy)
      begin
         qcnt <= tick ? 8'h00 : qcnt + 8'h01;
         if (tick)
         begin
            quarter <= quarter + 2'h1;
            if (quarter == 2'h3)
            begin
               if ((kind == STEP_RXA || kind == STEP_RXN) && bit_idx < 4'h8)
                  rx <= {rx[14:0], sda_sync};                                // [R16]
               if (kind == STEP_START || kind == STEP_STOP || bit_idx == 4'h8)
               begin
                  bit_idx <= 4'h0;
                  step <= step + 4'h1;
                  if (kind == STEP_TX && sda_sync)
                  begin
                     nack <= 1'b1;
                     step <= stop_index(op);                                 // [R11]
                  end
               end
               else
                  bit_idx <= bit_idx + 4'h1;
            end
         end
      end
   end

   // pin drive: scl high in the last two quarters, sda moved at quarter one or three
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         link.scl_out <= 1'b1;
         link.scl_oe <= 1'b0;
         link.sda_host_out <= 1'b0;
         link.sda_host_oe <= 1'b0;
         link.hvc_elevated <= 1'b0;
      end
      else
      begin
         link.scl_oe <= 1'b1;
         link.scl_out <= !busy || kind == STEP_END || quarter[1];
         link.hvc_elevated <= busy && cmd[CMDF_HV_BIT];                      // [R4]
         if (!busy || kind == STEP_END)
            link.sda_host_oe <= 1'b0;
         else if (quarter == 2'h1)
         begin
            case (kind)
               STEP_STOP: link.sda_host_oe <= 1'b1;
               STEP_TX: link.sda_host_oe <= (bit_idx < 4'h8) && !tx_byte[3'(4'h7 - bit_idx)];
               STEP_RXA: link.sda_host_oe <= (bit_idx == 4'h8);
               default: link.sda_host_oe <= 1'b0;
            endcase
         end
         // only start and stop may move sda while scl is high
         else if (quarter == 2'h3 && qcnt == 8'h00 && (kind == STEP_START || kind == STEP_STOP))
            link.sda_host_oe <= (kind == STEP_START);                        // [R3]
      end
   end

endmodule : dpcd_host

// ---- dpcd_chk.sv ----
`timescale 1ns/10ps
module dpcd_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_out,
   input wire logic sda_dev_oe,
   input wire logic hvc_elevated
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // link checks between host and device
   property p_od; sda_dev_oe |-> !sda_dev_out; endproperty
   a_od: assert property (p_od) else $error("device drove sda high");
   property p_low; $rose(sda_dev_oe) |-> !scl && $past(!scl, 3); endproperty
   a_low: assert property (p_low) else $error("device drive began outside scl low");
   property p_edge; $changed(sda_dev_oe) |-> !scl; endproperty
   a_edge: assert property (p_edge) else $error("device sda moved with scl high");
   property p_hv; sda_dev_oe && $past(sda_dev_oe) |-> $stable(hvc_elevated); endproperty
   a_hv: assert property (p_hv) else $error("hv level moved in transfer");
   property p_hi; $rose(scl) |-> scl [*8]; endproperty
   a_hi: assert property (p_hi) else $error("scl high phase short");
   property p_lo; $fell(scl) |-> !scl [*8]; endproperty
   a_lo: assert property (p_lo) else $error("scl low phase short");
   property p_amin; $rose(sda_dev_oe) |-> sda_dev_oe [*8]; endproperty
   a_amin: assert property (p_amin) else $error("device drive too short");
   property p_amax; sda_dev_oe |-> ##[1:1000] !sda_dev_oe; endproperty
   a_amax: assert property (p_amax) else $error("device holds sda too long");
endmodule : dpcd_chk

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import dpcd_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, st;
   logic pready, pslverr, perr, hvs, cerr;
   logic [8:0] w0, w1, tc;
   int mismatches = 0, n_tests = 0;
   dpcd_link_if u_dpcd_link_if ();
   dpcd_device u_dpcd_device (.pclk(pclk), .presetn(presetn), .link(u_dpcd_link_if.device),
      .wiper_zero_setting(w0), .wiper_one_setting(w1), .terminal_connection_control(tc),
      .high_voltage_state(hvs), .command_error(cerr));
   dpcd_host u_dpcd_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(u_dpcd_link_if.host));
   dpcd_chk u_dpcd_chk (.pclk(pclk), .presetn(presetn), .scl(u_dpcd_link_if.scl),
      .sda(u_dpcd_link_if.sda), .sda_dev_out(u_dpcd_link_if.sda_dev_out),
      .sda_dev_oe(u_dpcd_link_if.sda_dev_oe), .hvc_elevated(u_dpcd_link_if.hvc_elevated));
   // clock, reset and watchdog
   initial forever #20 pclk = ~pclk;
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
   end
   initial
   begin
      #(90000 * 40);
      mismatches++;
      wrap_up();
   end
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      st = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // send a command, then poll until idle
   task automatic cmd(input logic [3:0] a, input logic [1:0] op, input logic hv,
      input logic [9:0] v);
      apb(1'h1, OFS_CMD, {14'h0, v, 1'h0, hv, op, a});
      do apb(1'h0, OFS_STATUS, 32'h0); while (st[STF_BUSY] !== 1'h0);
   endtask : cmd
   task automatic wrap_up();
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // command sequence
   initial
   begin
      repeat (3) @(posedge pclk);
      cmd(ADDR_WIPER_ONE, OP_READ, 1'h0, 10'h0);
      chk("rd_w1", 10'h080, st[25:16]);
      cmd(ADDR_WIPER_ZERO, OP_WRITE, 1'h0, 10'h2FF);
      chk("w0_wr", 10'h0FF, 10'(w0));
      cmd(ADDR_WIPER_ZERO, OP_INC, 1'h0, 10'h0);
      chk("w0_inc", 10'h100, 10'(w0));
      cmd(ADDR_WIPER_ZERO, OP_INC, 1'h0, 10'h0);
      chk("w0_sat", 10'h100, 10'(w0));
      cmd(ADDR_WIPER_ZERO, OP_DEC, 1'h1, 10'h0);
      chk("w0_dec", 10'h0FF, 10'(w0));
      chk("hv", 10'h1, 10'(hvs));
      cmd(ADDR_WIPER_ZERO, OP_READ, 1'h0, 10'h0);
      chk("rd_w0", 10'h0FF, st[25:16]);
      cmd(ADDR_WIPER_ONE, OP_WRITE, 1'h0, 10'h100);
      chk("w1_full", 10'h100, 10'(w1));
      cmd(ADDR_WIPER_ONE, OP_READ, 1'h0, 10'h0);
      chk("rd_w1_full", 10'h100, st[25:16]);
      cmd(ADDR_TERMINAL_CONNECTION_CONTROL, OP_WRITE, 1'h0, 10'h055);
      chk("tc_wr", 10'h055, 10'(tc));
      cmd(ADDR_TERMINAL_CONNECTION_CONTROL, OP_INC, 1'h0, 10'h0);
      chk("tc_inc_nack", 10'h1, 10'(st[STF_NACK]));
      chk("tc_kept", 10'h055, 10'(tc));
      chk("err_set", 10'h1, 10'(cerr));
      cmd(ADDR_STATUS, OP_READ, 1'h0, 10'h0);
      chk("st_ack", 10'h0, 10'(st[STF_NACK]));
      chk("err_clr", 10'h0, 10'(cerr));
      chk("st_rd", 10'h000, st[25:16]);
      cmd(4'h2, OP_WRITE, 1'h0, 10'h0);
      chk("rsv_nack", 10'h1, 10'(st[STF_NACK]));
      apb(1'h1, 32'h0000_0008, 32'h0);
      chk("unmapped", 10'h1, 10'(perr));
      wrap_up();
   end
endmodule : testbench
